// ---- rtl/rtsc_map.svh ----
// Register map and field positions of the reference control block
`ifndef RTSC_MAP_SVH
`define RTSC_MAP_SVH
`define RTSC_CTRL_ADDR 12'h90c
`define RTSC_ADDR_W 12
`define RTSC_CTRL_RESET 8'h00
`define RTSC_BIT_REF_EN 7
`define RTSC_BIT_READY 6
`define RTSC_BIT_TS_EN 5
`define RTSC_BIT_TS_RANGE 4
`define RTSC_CMP_HI 3
`define RTSC_CMP_LO 2
`define RTSC_CNV_HI 1
`define RTSC_CNV_LO 0
`define RTSC_HTRANS_NONSEQ 2'b10
`define RTSC_HTRANS_BIT 1
`define RTSC_HRESP_OKAY 1'b0
`define RTSC_SETTLE_MS 200
`define RTSC_CLK_MHZ 200
`endif

// ---- rtl/rtsc_pkg.sv ----
// Types of the reference control block
`default_nettype none
package rtsc_pkg;
  typedef enum logic [1:0] {
    RTSC_GAIN_OFF,
    RTSC_GAIN_X1,
    RTSC_GAIN_X2,
    RTSC_GAIN_X4
  } rtsc_gain_e;
  typedef struct packed {
    logic refEnable;
    logic tempSenseEnable;
    logic tempSenseRange;
    rtsc_gain_e comparatorGain;
    rtsc_gain_e converterGain;
  } rtsc_analog_s;
endpackage
`default_nettype wire

// ---- rtl/rtsc_gain_decode.sv ----
// Decoder of one two-bit buffer gain field
`timescale 1ns/1ps
`default_nettype none
module rtsc_gain_decode (
  input wire logic [1:0] field,
  output rtsc_pkg::rtsc_gain_e gain,
  output logic bufferOn
);
  always_comb begin
    unique case (field)
      2'h3: gain = rtsc_pkg::RTSC_GAIN_X4;
      2'h2: gain = rtsc_pkg::RTSC_GAIN_X2;
      2'h1: gain = rtsc_pkg::RTSC_GAIN_X1;
      2'h0: gain = rtsc_pkg::RTSC_GAIN_OFF;
    endcase
  end
  assign bufferOn = (field != 2'h0);
endmodule
`default_nettype wire

// ---- rtl/rtsc_reference_control.sv ----
// AHB-Lite slave holding the reference and temperature sense control
`timescale 1ns/1ps
`default_nettype none
`include "rtsc_map.svh"
// Behaviour
// - Reference enable output follows control bit 7.
// - Ready flag bit 6 always reads one; writes ignored.
// - Temperature sense enable output follows control bit 5.
// - Bit 4 selects high range when one, low range when zero.
// - Bits 3:2 give comparator buffer gain 4x, 2x, 1x or off.
// - Bits 1:0 give converter buffer gain 4x, 2x, 1x or off.
module rtsc_reference_control (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output rtsc_pkg::rtsc_analog_s analogCtrl,
  output logic comparatorBufferOn,
  output logic converterBufferOn
);
  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic wrPend_q;
  logic rdPend_q;
  logic hit;
  logic [7:0] ctrl_q;
  logic [7:0] readValue;

  function automatic logic addrHit(input logic [31:0] a);
    addrHit = (a[31:`RTSC_ADDR_W] == '0) &&
              (a[`RTSC_ADDR_W-1:0] == `RTSC_CTRL_ADDR);
  endfunction

  assign hit = hsel && hready && htrans[`RTSC_HTRANS_BIT] && addrHit(haddr);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
    end else begin
      wrPend_q <= hit && hwrite;
      rdPend_q <= hit && !hwrite;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= `RTSC_CTRL_RESET;
    end else if (wrPend_q) begin
      ctrl_q <= hwdata[7:0];
    end
  end

  always_comb begin
    readValue = wrPend_q ? hwdata[7:0] : ctrl_q;
    readValue[`RTSC_BIT_READY] = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (hit && !hwrite) begin
      hrdata <= {24'h000000, readValue};
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = `RTSC_HRESP_OKAY;

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  rtsc_pkg::rtsc_gain_e cmpGain;
  rtsc_pkg::rtsc_gain_e cnvGain;

  rtsc_gain_decode u_cmp_decode (
    .field(ctrl_q[`RTSC_CMP_HI:`RTSC_CMP_LO]),
    .gain(cmpGain),
    .bufferOn(comparatorBufferOn)
  );

  rtsc_gain_decode u_cnv_decode (
    .field(ctrl_q[`RTSC_CNV_HI:`RTSC_CNV_LO]),
    .gain(cnvGain),
    .bufferOn(converterBufferOn)
  );

  always_comb begin
    analogCtrl.refEnable = ctrl_q[`RTSC_BIT_REF_EN];
    analogCtrl.tempSenseEnable = ctrl_q[`RTSC_BIT_TS_EN];
    analogCtrl.tempSenseRange = ctrl_q[`RTSC_BIT_TS_RANGE];
    analogCtrl.comparatorGain = cmpGain;
    analogCtrl.converterGain = cnvGain;
  end

  // ----------------------------------------------------------------
  // Assertions: register and bus
  // ----------------------------------------------------------------
  a_ref_enable: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q |=>
      analogCtrl.refEnable == $past(hwdata[`RTSC_BIT_REF_EN]))
    else $error("reference enable does not follow write");
  a_ready_one: assert property (@(posedge ref_clk)
    disable iff (reset)
      rdPend_q |-> hrdata[`RTSC_BIT_READY])
    else $error("ready flag read as zero");
  a_ts_enable: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q |=>
      analogCtrl.tempSenseEnable == $past(hwdata[`RTSC_BIT_TS_EN]))
    else $error("temp sense enable does not follow write");
  a_ts_range: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q |=>
      analogCtrl.tempSenseRange == $past(hwdata[`RTSC_BIT_TS_RANGE]))
    else $error("range select does not follow write");
  a_read_value: assert property (@(posedge ref_clk)
    disable iff (reset) rdPend_q |-> hrdata[31:8] == 24'h000000 &&
      hrdata[`RTSC_BIT_TS_EN:0] == ctrl_q[`RTSC_BIT_TS_EN:0] &&
      hrdata[`RTSC_BIT_REF_EN] == ctrl_q[`RTSC_BIT_REF_EN])
    else $error("read data mismatch");
  a_read_quiet: assert property (@(posedge ref_clk)
    disable iff (reset)
      !wrPend_q |=> $stable(ctrl_q))
    else $error("control changed without write");
  a_struct_hold: assert property (@(posedge ref_clk)
    disable iff (reset)
      !wrPend_q |=> $stable(analogCtrl))
    else $error("analog controls changed without write");
  a_rdata_idle: assert property (@(posedge ref_clk)
    disable iff (reset)
      !rdPend_q |-> hrdata == 32'h00000000)
    else $error("read data not zero outside read phase");
  a_read_forward: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && hit && !hwrite |=>
      hrdata[`RTSC_BIT_REF_EN] == $past(hwdata[`RTSC_BIT_REF_EN]))
    else $error("read after write returned stale data");
  a_reset_clear: assert property (@(posedge ref_clk)
    reset |=>
      ctrl_q == `RTSC_CTRL_RESET && hrdata == 32'h00000000)
    else $error("reset did not clear control");

  // ----------------------------------------------------------------
  // Assertions: gain decode
  // ----------------------------------------------------------------
  logic [1:0] wrCmpField;
  logic [1:0] wrCnvField;
  assign wrCmpField = hwdata[`RTSC_CMP_HI:`RTSC_CMP_LO];
  assign wrCnvField = hwdata[`RTSC_CNV_HI:`RTSC_CNV_LO];

  a_cmp_gain: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCmpField == 2'h3 |=>
      analogCtrl.comparatorGain == rtsc_pkg::RTSC_GAIN_X4)
    else $error("comparator gain decode wrong");
  a_cmp_x2: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCmpField == 2'h2 |=>
      analogCtrl.comparatorGain == rtsc_pkg::RTSC_GAIN_X2)
    else $error("comparator gain not two times");
  a_cmp_x1: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCmpField == 2'h1 |=>
      analogCtrl.comparatorGain == rtsc_pkg::RTSC_GAIN_X1)
    else $error("comparator gain not unity");
  a_cmp_zero: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCmpField == 2'h0 |=>
      analogCtrl.comparatorGain == rtsc_pkg::RTSC_GAIN_OFF &&
      !comparatorBufferOn)
    else $error("comparator buffer not switched off");
  a_cmp_off: assert property (@(posedge ref_clk)
    disable iff (reset)
      comparatorBufferOn == (ctrl_q[`RTSC_CMP_HI:`RTSC_CMP_LO] != 2'h0))
    else $error("comparator buffer on wrong");
  a_cmp_on: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q |=>
      comparatorBufferOn == ($past(wrCmpField) != 2'h0))
    else $error("comparator buffer state does not follow write");
  a_cnv_gain: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCnvField == 2'h2 |=>
      analogCtrl.converterGain == rtsc_pkg::RTSC_GAIN_X2)
    else $error("converter gain decode wrong");
  a_cnv_x4: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCnvField == 2'h3 |=>
      analogCtrl.converterGain == rtsc_pkg::RTSC_GAIN_X4)
    else $error("converter gain not four times");
  a_cnv_x1: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCnvField == 2'h1 |=>
      analogCtrl.converterGain == rtsc_pkg::RTSC_GAIN_X1)
    else $error("converter gain not unity");
  a_cnv_zero: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q && wrCnvField == 2'h0 |=>
      analogCtrl.converterGain == rtsc_pkg::RTSC_GAIN_OFF &&
      !converterBufferOn)
    else $error("converter buffer not switched off");
  a_cnv_off: assert property (@(posedge ref_clk)
    disable iff (reset)
      converterBufferOn == (ctrl_q[`RTSC_CNV_HI:`RTSC_CNV_LO] != 2'h0))
    else $error("converter buffer on wrong");
  a_cnv_on: assert property (@(posedge ref_clk)
    disable iff (reset) wrPend_q |=>
      converterBufferOn == ($past(wrCnvField) != 2'h0))
    else $error("converter buffer state does not follow write");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_write: cover property (@(posedge ref_clk) disable iff (reset)
    wrPend_q);
  c_read: cover property (@(posedge ref_clk) disable iff (reset)
    rdPend_q);
  c_ref_on: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(analogCtrl.refEnable));
  c_wr_rd: cover property (@(posedge ref_clk) disable iff (reset)
    wrPend_q ##1 rdPend_q);
  c_ts_high: cover property (@(posedge ref_clk) disable iff (reset)
    analogCtrl.tempSenseEnable && analogCtrl.tempSenseRange);
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench of the reference control register
`timescale 1ns/1ps
`default_nettype none
`include "rtsc_map.svh"
module testbench;
  logic refClk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic cmpOn;
  logic cnvOn;
  rtsc_pkg::rtsc_analog_s analogCtrl;
  int errCount = 0;
  int totalChecks = 0;
  integer seed = 32'h2e345d89;
  logic [7:0] val = 8'h00;
  logic [7:0] corner [6] = '{8'hff, 8'h00, 8'h40, 8'hbf, 8'h05, 8'h0a};
  localparam logic [31:0] ADDR = {20'h0, `RTSC_CTRL_ADDR};
  always #2.5 refClk = ~refClk;
  rtsc_reference_control rtsc_reference_control_inst (
    .ref_clk(refClk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .analogCtrl(analogCtrl),
    .comparatorBufferOn(cmpOn), .converterBufferOn(cnvOn)
  );
  function automatic logic [31:0] expRead(input logic [7:0] v);
    return {24'h0, v[7], 1'b1, v[5:0]};
  endfunction
  function automatic logic [31:0] expCtrl(input logic [7:0] v);
    return {25'h0, v[7], v[5:0]};
  endfunction
  task automatic endOfTest();
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Single AHB-Lite transfer, read data kept in rd
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge refClk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `RTSC_HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge refClk);
    while (hreadyout !== 1'b1) @(posedge refClk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge refClk);
    while (hreadyout !== 1'b1) @(posedge refClk);
    rd = hrdata;
  endtask
  // Write, then a read whose address phase meets the write data phase
  task automatic wrRd(input logic [7:0] v);
    @(posedge refClk);
    hsel <= 1'b1;
    haddr <= ADDR;
    htrans <= `RTSC_HTRANS_NONSEQ;
    hwrite <= 1'b1;
    @(posedge refClk);
    while (hreadyout !== 1'b1) @(posedge refClk);
    hwrite <= 1'b0;
    hwdata <= {24'h0, v};
    @(posedge refClk);
    while (hreadyout !== 1'b1) @(posedge refClk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    @(posedge refClk);
    while (hreadyout !== 1'b1) @(posedge refClk);
    rd = hrdata;
  endtask
  task automatic wrChk(input logic [7:0] v);
    bus(1'b1, ADDR, {24'h0, v});
    #1;
    chk("analogCtrl", expCtrl(v), {25'h0, analogCtrl});
    chk("comparatorBufferOn", {31'h0, |v[3:2]}, {31'h0, cmpOn});
    chk("converterBufferOn", {31'h0, |v[1:0]}, {31'h0, cnvOn});
    chk("idleRdata", 32'h0, hrdata);
    bus(1'b0, ADDR, 32'h0);
    chk("readBack", expRead(v), rd);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge refClk);
    reset <= 1'b0;
    bus(1'b0, ADDR, 32'h0);
    chk("resetRead", 32'h40, rd);
    chk("resetCtrl", 32'h0, {25'h0, analogCtrl});
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    foreach (corner[i]) wrChk(corner[i]);
    // Sensor on in high range, both gain buffers off
    wrChk(8'h30);
    foreach (corner[i]) begin
      wrRd(corner[i]);
      chk("pipeRead", expRead(corner[i]), rd);
    end
    repeat (24) begin
      val = 8'($random(seed));
      wrChk(val);
    end
    bus(1'b1, 32'h910, 32'hff);
    #1;
    chk("unmappedCtrl", expCtrl(val), {25'h0, analogCtrl});
    bus(1'b0, 32'h910, 32'h0);
    chk("unmappedRead", 32'h0, rd);
    bus(1'b1, 32'h1000090c, 32'hff);
    #1;
    chk("aliasCtrl", expCtrl(val), {25'h0, analogCtrl});
    bus(1'b0, 32'h1000090c, 32'h0);
    chk("aliasRead", 32'h0, rd);
    bus(1'b0, ADDR, 32'h0);
    chk("keptRead", expRead(val), rd);
    endOfTest();
  end
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #50000;
    errCount++;
    endOfTest();
  end
endmodule
`default_nettype wire
